// [mpi_pkg.sv]
// mpi_pkg: constants shared by the motor pwm interrupt status block
// assumes a 32-bit avalon-mm byte address and a 100 MHz system clock

// ****************************************************************
// package
// ****************************************************************
package mpi_pkg;

    // bus shape
    localparam int          ADDR_W        = 32;
    localparam int          DATA_W        = 32;
    localparam int          BE_W          = 4;

    // register byte addresses
    localparam logic [31:0] STATUS_ADDR   = 32'h4000_4030;
    localparam logic [31:0] ENABLE_ADDR   = 32'h4000_4034;

    // event widths
    localparam int          NUM_CHAN      = 6;
    localparam int          FLAG_W        = 8;
    localparam int          CNT_W         = 3;

    // status field positions
    localparam int          PERIOD_BIT    = 7;
    localparam int          BOTTOM_BIT    = 6;
    localparam int          CHAN_LSB      = 0;
    localparam int          CNT_LSB       = 12;
    localparam int          DIR_BIT       = 15;

    // enable field positions
    localparam int          PERIOD_EN_BIT = 7;
    localparam int          BOTTOM_EN_BIT = 6;

    // byte lanes holding each field
    localparam int          FLAG_LANE     = 0;
    localparam int          CNT_LANE      = 1;

    // reset values
    localparam logic [7:0]  FLAG_RST      = 8'h00;
    localparam logic [7:0]  ENABLE_RST    = 8'h00;
    localparam logic [2:0]  CNT_RST       = 3'h0;
    localparam logic [31:0] RDATA_RST     = 32'h0000_0000;

    // bus handshake states
    typedef enum logic {
        MPI_BUS_IDLE,
        MPI_BUS_ACK
    } mpi_bus_state_t;

endpackage : mpi_pkg

// [mpi_irq_status.sv]
// mpi_irq_status: interrupt enable and status logic of a three-phase pwm unit
// assumes match, period and bottom strobes are one-cycle pulses on i_clk_sys
// and the trigger-mode selects are levels from logic on the same clock
//
// Notes on behaviour
// RULE1: enable bit 7 lets a period event raise the interrupt; 0 blocks it
// RULE2: enable bit 6 lets a bottom event raise the interrupt; 0 blocks it
// RULE3: enable bits 5..0 gate the six channel or trigger match interrupts
// RULE4: each low flag and enable serves duty match or trigger match, one at a time
// RULE5: trigger mode off selects duty match; otherwise trigger counter match sets flag
// RULE6: the per-channel trigger mode input chooses the source of each shared bit
// RULE7: period flag bit 7 and bottom flag bit 6 set on event, write one clears
// RULE8: channel flags bits 5..0 set on match; write one clears, zero keeps
// RULE9: status bit 15 reads 0 counting up and 1 counting down
// RULE10: software keeps every duty value nonzero, zero duty stops the pwm
// RULE11: interrupt stays high while any enabled flag is set
// RULE12: status bits 14..12 count period matches for interval period interrupts; o_irq ignores the count and follows the period flag on every match
`timescale 1ns/1ps

module mpi_irq_status (
    // clock and reset
    input  wire logic                          i_clk_sys,
    input  wire logic                          i_reset,
    // avalon-mm slave
    input  wire logic [mpi_pkg::ADDR_W-1:0]    i_avs_address,
    input  wire logic                          i_avs_read,
    input  wire logic                          i_avs_write,
    input  wire logic [mpi_pkg::DATA_W-1:0]    i_avs_writedata,
    input  wire logic [mpi_pkg::BE_W-1:0]      i_avs_byteenable,
    output logic      [mpi_pkg::DATA_W-1:0]    o_avs_readdata,
    output logic                               o_avs_waitrequest,
    // pwm counter events
    input  wire logic                          i_period_evt,
    input  wire logic                          i_bottom_evt,
    input  wire logic                          i_count_down,
    // channel events, bit 5 = w high / trigger 6 ... bit 0 = u low / trigger 1
    input  wire logic [mpi_pkg::NUM_CHAN-1:0]  i_duty_match,
    input  wire logic [mpi_pkg::NUM_CHAN-1:0]  i_trig_match,
    input  wire logic [mpi_pkg::NUM_CHAN-1:0]  i_trig_mode_on,
    // interrupt request
    output logic                               o_irq
);
    import mpi_pkg::*;

    // ****************************************************************
    // state
    // ****************************************************************
    mpi_bus_state_t          bus_state_ff;
    logic                    waitreq_ff;
    logic [DATA_W-1:0]       rdata_ff;
    logic [FLAG_W-1:0]       flag_ff;
    logic [FLAG_W-1:0]       enable_ff;
    logic [CNT_W-1:0]        period_cnt_ff;
    logic                    irq_ff;

    logic [FLAG_W-1:0]       nxt_flag;
    logic [CNT_W-1:0]        nxt_period_cnt;
    logic [NUM_CHAN-1:0]     chan_set;
    logic [FLAG_W-1:0]       flag_set;
    logic                    bus_req;
    logic                    bus_take;
    logic                    hit_status;
    logic                    hit_enable;
    logic                    wr_status;
    logic                    wr_enable;
    logic [DATA_W-1:0]       rd_mux;

    // ****************************************************************
    // event source selection
    // ****************************************************************

    // each shared bit takes trigger match in trigger mode, duty match otherwise
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CHAN; gi++) begin : g_src
            assign chan_set[gi] = i_trig_mode_on[gi] ? i_trig_match[gi]  // RULE6
                                                     : i_duty_match[gi]; // RULE5
        end
    endgenerate

    // all eight hardware set terms in status layout
    assign flag_set = {i_period_evt, i_bottom_evt, chan_set};             // RULE4

    // ****************************************************************
    // avalon-mm decode
    // ****************************************************************

    // a request is taken on the edge where waitrequest is seen low
    assign bus_req  = i_avs_read | i_avs_write;
    assign bus_take = bus_req & ~waitreq_ff;

    // address decode
    always_comb begin
        hit_status = 1'b0;
        hit_enable = 1'b0;
        if (i_avs_address == STATUS_ADDR) begin
            hit_status = 1'b1;
        end else if (i_avs_address == ENABLE_ADDR) begin
            hit_enable = 1'b1;
        end
    end

    assign wr_status = bus_take & i_avs_write & hit_status;
    assign wr_enable = bus_take & i_avs_write & hit_enable;

    // read mux, unmapped addresses read zero
    always_comb begin
        rd_mux = RDATA_RST;
        if (hit_status) begin
            rd_mux[DIR_BIT]                   = i_count_down;     // RULE9
            rd_mux[CNT_LSB +: CNT_W]          = period_cnt_ff;
            rd_mux[FLAG_W-1:0]                = flag_ff;
        end else if (hit_enable) begin
            rd_mux[FLAG_W-1:0]                = enable_ff;
        end
    end

    // ****************************************************************
    // bus handshake
    // ****************************************************************

    // one wait cycle, then waitrequest low for exactly one cycle
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            bus_state_ff <= MPI_BUS_IDLE;
            waitreq_ff   <= 1'b1;
        end else begin
            case (bus_state_ff)
                MPI_BUS_IDLE: begin
                    if (bus_req) begin
                        bus_state_ff <= MPI_BUS_ACK;
                        waitreq_ff   <= 1'b0;
                    end
                end
                MPI_BUS_ACK: begin
                    bus_state_ff <= MPI_BUS_IDLE;
                    waitreq_ff   <= 1'b1;
                end
                default: begin
                    bus_state_ff <= MPI_BUS_IDLE;
                    waitreq_ff   <= 1'b1;
                end
            endcase
        end
    end

    // read data captured with the request so it stands at the taking edge
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            rdata_ff <= RDATA_RST;
        end else if (bus_state_ff == MPI_BUS_IDLE && i_avs_read) begin
            rdata_ff <= rd_mux;
        end else if (bus_take) begin
            rdata_ff <= RDATA_RST;
        end
    end

    // ****************************************************************
    // enable register
    // ****************************************************************

    // software written gates for the eight interrupt sources
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            enable_ff <= ENABLE_RST;
        end else if (wr_enable && i_avs_byteenable[FLAG_LANE]) begin
            enable_ff <= i_avs_writedata[FLAG_W-1:0];
        end
    end

    // ****************************************************************
    // sticky flags
    // ****************************************************************

    // write one clears, a set in the same cycle wins over the clear
    always_comb begin
        nxt_flag = flag_ff;
        if (wr_status && i_avs_byteenable[FLAG_LANE]) begin
            nxt_flag = flag_ff & ~i_avs_writedata[FLAG_W-1:0];     // RULE8
        end
        nxt_flag = nxt_flag | flag_set;                            // RULE7
    end

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            flag_ff <= FLAG_RST;
        end else begin
            flag_ff <= nxt_flag;
        end
    end

    // ****************************************************************
    // period match interval count
    // ****************************************************************

    // software may load the count; a period match in the same cycle wins
    always_comb begin
        nxt_period_cnt = period_cnt_ff;
        if (wr_status && i_avs_byteenable[CNT_LANE]) begin
            nxt_period_cnt = i_avs_writedata[CNT_LSB +: CNT_W];
        end
        if (i_period_evt) begin
            nxt_period_cnt = period_cnt_ff + 3'h1;                 // RULE12
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            period_cnt_ff <= CNT_RST;
        end else begin
            period_cnt_ff <= nxt_period_cnt;
        end
    end

    // ****************************************************************
    // interrupt request
    // ****************************************************************

    // level output, high while any flag set under its enable
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= (flag_ff[PERIOD_BIT] & enable_ff[PERIOD_EN_BIT])   // RULE1
                    | (flag_ff[BOTTOM_BIT] & enable_ff[BOTTOM_EN_BIT])   // RULE2
                    | (|(flag_ff[NUM_CHAN-1:0] & enable_ff[NUM_CHAN-1:0])); // RULE3 RULE11
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign o_avs_readdata    = rdata_ff;
    assign o_avs_waitrequest = waitreq_ff;
    assign o_irq             = irq_ff;

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);

    // a status write that clears bits, with no set pending
    sequence s_clear_write(int b);
        wr_status && i_avs_byteenable[FLAG_LANE] && i_avs_writedata[b] && !flag_set[b];
    endsequence

    // a period event, whether or not software loads the count in the same cycle
    sequence s_period_only;
        i_period_evt;
    endsequence

    // request seen while the slave still waits
    sequence s_req_waiting;
        bus_req && waitreq_ff;
    endsequence

    period_flag_set_a: assert property (i_period_evt |=> flag_ff[PERIOD_BIT]) // RULE7
        else $error("period event did not set its flag");

    bottom_flag_set_a: assert property (i_bottom_evt |=> flag_ff[BOTTOM_BIT]) // RULE7
        else $error("bottom event did not set its flag");

    generate
        for (gi = 0; gi < NUM_CHAN; gi++) begin : g_chk
            duty_source_a: assert property (                       // RULE5
                (!i_trig_mode_on[gi] && i_duty_match[gi]) |=> flag_ff[gi])
                else $error("duty match did not set channel flag");

            trig_source_a: assert property (                       // RULE6
                (i_trig_mode_on[gi] && i_trig_match[gi]) |=> flag_ff[gi])
                else $error("trigger match did not set channel flag");

            flag_cause_a: assert property (                        // RULE4
                $rose(flag_ff[gi]) |-> $past(chan_set[gi]))
                else $error("channel flag rose without its selected source");

            flag_clear_a: assert property (s_clear_write(gi) |=> !flag_ff[gi]) // RULE8
                else $error("write one did not clear channel flag");

            flag_hold_a: assert property (                         // RULE8
                (flag_ff[gi] && !(wr_status && i_avs_byteenable[FLAG_LANE]
                                  && i_avs_writedata[gi])) |=> flag_ff[gi])
                else $error("channel flag dropped without a write one");
        end
    endgenerate

    period_clear_a: assert property (s_clear_write(PERIOD_BIT) |=> !flag_ff[PERIOD_BIT]) // RULE7
        else $error("write one did not clear period flag");

    bottom_clear_a: assert property (                              // RULE7
        s_clear_write(BOTTOM_BIT) |=> !flag_ff[BOTTOM_BIT])
        else $error("write one did not clear bottom flag");

    irq_level_a: assert property (                                 // RULE11
        ##1 (irq_ff == $past(|(flag_ff & enable_ff))))
        else $error("interrupt does not follow enabled flags");

    irq_blocked_a: assert property (                               // RULE1
        (enable_ff == ENABLE_RST) [*2] |-> !irq_ff)
        else $error("interrupt raised with every source disabled");

    irq_bottom_a: assert property (                                // RULE2
        (flag_ff == 8'h40 && enable_ff[BOTTOM_EN_BIT]) |=> irq_ff)
        else $error("enabled bottom flag raised no interrupt");

    irq_chan_a: assert property (                                  // RULE3
        (|(flag_ff[NUM_CHAN-1:0] & enable_ff[NUM_CHAN-1:0])) |=> irq_ff)
        else $error("enabled channel flag raised no interrupt");

    count_step_a: assert property (                                // RULE12
        s_period_only |=> period_cnt_ff == $past(period_cnt_ff) + 3'h1)
        else $error("interval count did not step on period match");

    dir_read_a: assert property (                                  // RULE9
        (i_avs_read && hit_status && bus_state_ff == MPI_BUS_IDLE)
        |=> rdata_ff[DIR_BIT] == $past(i_count_down))
        else $error("direction bit misreported");

    bus_answer_a: assert property (
        s_req_waiting |=> !waitreq_ff ##1 waitreq_ff)
        else $error("slave did not answer after one wait cycle");

    irq_period_a: assert property (                                // RULE1
        (flag_ff[PERIOD_BIT] && enable_ff[PERIOD_EN_BIT]) |=> irq_ff)
        else $error("enabled period flag raised no interrupt");

    enable_write_a: assert property (                              // RULE3
        (wr_enable && i_avs_byteenable[FLAG_LANE])
        |=> enable_ff == $past(i_avs_writedata[FLAG_W-1:0]))
        else $error("enable write did not land");

    count_load_a: assert property (                                // RULE12
        (wr_status && i_avs_byteenable[CNT_LANE] && !i_period_evt)
        |=> period_cnt_ff == $past(i_avs_writedata[CNT_LSB +: CNT_W]))
        else $error("interval count load did not land");

    count_hold_a: assert property (                                // RULE12
        (!i_period_evt && !(wr_status && i_avs_byteenable[CNT_LANE]))
        |=> $stable(period_cnt_ff))
        else $error("interval count moved with no period match");

    read_release_a: assert property (
        bus_take |=> rdata_ff == RDATA_RST)
        else $error("read data did not return to zero after the answer");

endmodule : mpi_irq_status

// [test_mpi_irq_status.sv]
// test_mpi_irq_status: self-checking bench for the pwm interrupt status block
// assumes mpi_pkg and mpi_irq_status are compiled first; one clock, no partner
`timescale 1ns/1ps

module test_mpi_irq_status;
    import mpi_pkg::*;

    // ****************************************************************
    // stimulus signals and expected state
    // ****************************************************************
    logic                clk, rst, rd_q, wr_q, prd_q, bot_q, down_q, irq;
    logic [ADDR_W-1:0]   addr_q;
    logic [DATA_W-1:0]   wdat_q, rdat;
    logic [BE_W-1:0]     be_q;
    logic                wait_req;
    logic [NUM_CHAN-1:0] duty_q, trig_q, mode_q;
    logic [FLAG_W-1:0]   exp_flags, exp_en;
    logic [CNT_W-1:0]    exp_cnt;
    int                  fail_count, comparisons;

    mpi_irq_status uut (
        .i_clk_sys(clk), .i_reset(rst), .i_avs_address(addr_q), .i_avs_read(rd_q),
        .i_avs_write(wr_q), .i_avs_writedata(wdat_q), .i_avs_byteenable(be_q),
        .o_avs_readdata(rdat), .o_avs_waitrequest(wait_req), .i_period_evt(prd_q),
        .i_bottom_evt(bot_q), .i_count_down(down_q), .i_duty_match(duty_q),
        .i_trig_match(trig_q), .i_trig_mode_on(mode_q), .o_irq(irq)
    );

    // free-running 100 MHz clock
    always #5 clk = ~clk;

    // ****************************************************************
    // helpers
    // ****************************************************************
    // status word as software should see it
    function automatic logic [31:0] exp_status();
        return {16'h0, down_q, exp_cnt, 4'h0, exp_flags};
    endfunction : exp_status

    // trigger mode picks the trigger match, otherwise the duty match
    function automatic logic [5:0] sel_src(input logic [5:0] m, d, t);
        return (m & t) | (~m & d);
    endfunction : sel_src

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : finish_test

    task automatic check(input string what, input logic [31:0] exp, got);
        comparisons++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
            fail_count++;
        end
    endtask : check

    // one avalon-mm transfer, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [31:0] a, wd, input logic [3:0] b,
                       output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk);
        addr_q <= a;
        rd_q   <= ~wr;
        wr_q   <= wr;
        wdat_q <= wd;
        be_q   <= b;
        // waitrequest and read data are taken as they stood at each rising edge
        do begin
            @(posedge clk);
            n++;
        end while (wait_req !== 1'b0 && n < 50);
        if (n >= 50) begin
            fail_count++;
            finish_test();
        end
        rd = rdat;
        rd_q <= 1'b0;
        wr_q <= 1'b0;
    endtask : bus

    // status write: lane 0 clears flags by write one, lane 1 loads the count
    task automatic wr_status(input logic [31:0] wd, input logic [3:0] b);
        logic [31:0] rd;
        bus(1'b1, STATUS_ADDR, wd, b, rd);
        if (b[0]) exp_flags = exp_flags & ~wd[7:0];
        if (b[1]) exp_cnt = wd[14:12];
    endtask : wr_status

    task automatic wr_en(input logic [31:0] wd);
        logic [31:0] rd;
        bus(1'b1, ENABLE_ADDR, wd, 4'hf, rd);
        exp_en = wd[7:0];
    endtask : wr_en

    // one cycle of event strobes, then quiet; duty strobes model a pwm on nonzero duty
    task automatic pulse(input logic p, b, input logic [5:0] d, t);
        @(posedge clk);
        prd_q  <= p;
        bot_q  <= b;
        duty_q <= d;
        trig_q <= t;
        @(posedge clk);
        {prd_q, bot_q, duty_q, trig_q} <= '0;
        exp_flags = exp_flags | {p, b, sel_src(mode_q, d, t)};
        if (p) exp_cnt = exp_cnt + 3'h1;
    endtask : pulse

    // read status and enable back, then look at the settled interrupt
    task automatic check_all(input string what);
        logic [31:0] rd;
        bus(1'b0, STATUS_ADDR, 32'h0, 4'hf, rd);
        check({what, " status"}, exp_status(), rd);
        bus(1'b0, ENABLE_ADDR, 32'h0, 4'hf, rd);
        check({what, " enable"}, {24'h0, exp_en}, rd);
        @(posedge clk);
        check({what, " irq"}, {31'h0, |(exp_flags & exp_en)}, {31'h0, irq});
    endtask : check_all

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        logic [31:0] rd;
        logic [1:0]  lane;
        {clk, rd_q, wr_q, prd_q, bot_q, down_q} = '0;
        {addr_q, wdat_q, be_q, duty_q, trig_q, mode_q} = '0;
        {exp_flags, exp_en, exp_cnt} = '0;
        rst = 1'b1;
        void'($urandom(32'h1f35fbcb));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        check_all("reset");
        $display("test reset done");

        // enable storage is eight bits wide, unmapped places answer zero
        wr_en(32'hffff_ffff);
        check_all("enable all");
        bus(1'b1, 32'h4000_4038, 32'hffff_ffff, 4'hf, rd);
        bus(1'b0, 32'h4000_4038, 32'h0, 4'hf, rd);
        check("unmapped read", 32'h0, rd);
        check_all("unmapped write");
        wr_en(32'h0);
        $display("test registers done");

        // each shared channel bit under both sources
        for (int m = 0; m < 2; m++) begin
            for (int i = 0; i < NUM_CHAN; i++) begin
                mode_q <= m[0] ? 6'h3f : 6'h00;
                pulse(1'b0, 1'b0, m[0] ? 6'h1 << i : 6'h0, m[0] ? 6'h0 : 6'h1 << i);
                check_all("unselected source");
                pulse(1'b0, 1'b0, m[0] ? 6'h0 : 6'h1 << i, m[0] ? 6'h1 << i : 6'h0);
                check_all("selected source");
                wr_en(32'h1 << i);
                check_all("channel enabled");
                wr_status(32'h0, 4'h1);
                check_all("write zero keeps");
                wr_status(32'h1 << i, 4'h1);
                check_all("channel cleared");
                wr_en(32'h0);
            end
        end
        $display("test channels done");

        // period and bottom flags behind their own enable bits
        for (int k = 6; k < 8; k++) begin
            pulse(k == 7, k == 6, 6'h0, 6'h0);
            check_all("counter event masked");
            wr_en(32'h1 << (13 - k));
            check_all("other enable only");
            wr_en(32'h1 << k);
            check_all("counter event enabled");
            wr_status(32'h1 << k, 4'h1);
            check_all("counter event cleared");
            wr_en(32'h0);
        end
        wr_status(32'h0000_5000, 4'h2);
        check_all("count load");
        $display("test counter events done");

        // random traffic against the bench model
        for (int n = 0; n < 80; n++) begin
            mode_q <= 6'($urandom);
            down_q <= 1'($urandom);
            if ($urandom_range(0, 3) == 0) wr_en($urandom);
            pulse(1'($urandom), 1'($urandom), 6'($urandom), 6'($urandom));
            if ($urandom_range(0, 2) == 0) begin
                lane = 2'($urandom_range(1, 3));
                wr_status($urandom, {2'b00, lane});
            end
            check_all("random");
        end
        $display("test random done");
        finish_test();
    end

endmodule : test_mpi_irq_status
